// ===== rtl/pss_pkg.sv
/*
 * Package for the parameter save and restore controller: register indices,
 * command keys, category bit positions and timing counts.
 * Assumes a single 100 MHz clock domain and a plain register port.
 */
package pss_pkg;
    // ------------------------------------------------------------------
    // Register addresses (word index on the plain register port).
    // ------------------------------------------------------------------
    localparam logic [4:0] PSS_A_STORE_ALL   = 5'h01; // Store all categories.
    localparam logic [4:0] PSS_A_STORE_LAST  = 5'h06; // Store tuning.
    localparam logic [4:0] PSS_A_DISC_ALL    = 5'h11; // Discard all but tuning.
    localparam logic [4:0] PSS_A_DISC_LAST   = 5'h16; // Discard tuning.
    localparam logic [4:0] PSS_A_REBOOT      = 5'h18; // Reboot settings subindex 1.
    localparam logic [4:0] PSS_A_MARKER0     = 5'h1A; // Configuration marker entry 1.
    localparam logic [4:0] PSS_A_MARKER1     = 5'h1B; // Configuration marker entry 2.
    localparam logic [4:0] PSS_A_STATUS      = 5'h1C; // Busy and pending flags.
    localparam logic [4:0] PSS_A_OBJECT      = 5'h1D; // Ordinary savable object write.
    localparam logic [4:0] PSS_A_ACTIVE_CAT  = 5'h1E; // Category valid mask in use.
    // ------------------------------------------------------------------
    // Command keys.
    // ------------------------------------------------------------------
    localparam logic [31:0] PSS_KEY_SAVE    = 32'h65766173;
    localparam logic [31:0] PSS_KEY_LOAD    = 32'h64616F6C;
    localparam logic [31:0] PSS_KEY_BOOT    = 32'h746F6F62;
    localparam logic [31:0] PSS_DONE_VALUE  = 32'h00000001;
    // ------------------------------------------------------------------
    // Category bits: 0 comm, 1 appl, 2 customer, 3 drive, 4 tuning.
    // ------------------------------------------------------------------
    localparam int          PSS_NCAT        = 5;
    localparam int          PSS_CAT_TUNING  = 4;
    localparam logic [4:0]  PSS_CAT_ALL     = 5'h1F;
    localparam logic [4:0]  PSS_CAT_FACTORY = 5'h0F;
    // ------------------------------------------------------------------
    // Timing: one category write to storage takes a fixed time.
    // ------------------------------------------------------------------
    localparam int PSS_CLK_MHZ       = 100;
    localparam int PSS_CAT_WRITE_US  = 100;
    localparam int PSS_CAT_CYCLES    = PSS_CAT_WRITE_US * PSS_CLK_MHZ;
    localparam int PSS_REBOOT_CYCLES = 16;

    typedef enum logic [1:0] {PSS_IDLE, PSS_STORE, PSS_DISCARD} pss_state_e;
endpackage : pss_pkg

// ===== rtl/pss_ctrl.sv
/*
 * Parameter save and restore controller. Holds the store and discard
 * command entries, steps through categories to the non-volatile storage
 * port, and reports all five categories reloaded after every reset.
 * Assumes the storage port answers each request with a one-cycle done
 * pulse and keeps its content across resets and firmware updates.
 */
`timescale 1ns/1ps
`default_nettype none

module pss_ctrl
    import pss_pkg::*;
(
    input  wire logic        clk,             // 100 MHz clock.
    input  wire logic        reset_n,         // Asynchronous active-low reset.
    input  wire logic [4:0]  reg_addr,        // Register index.
    input  wire logic [31:0] reg_wdata,       // Write data.
    input  wire logic        reg_wr,          // Write strobe.
    input  wire logic        reg_rd,          // Read strobe.
    output logic      [31:0] reg_rdata,       // Read data, cycle after strobe.
    output logic             nv_req,          // Storage request, one pulse.
    output logic             nv_write,        // 1 store, 0 erase.
    output logic      [2:0]  nv_cat,          // Category index of request.
    input  wire logic        nv_done,         // Storage finished request.
    output logic      [4:0]  restored_cats,   // Categories loaded at reset.
    output logic             restart_req,     // Restart request pulse.
    output logic             busy             // Save or discard in progress.
);
    // ------------------------------------------------------------------
    // Reset synchroniser.
    // ------------------------------------------------------------------
    logic rst_meta_r;   // First stage, read only by the second.
    logic rst_n_r;      // Released reset used by the block.

    // Release reset through two flops so all logic leaves reset together.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Decode helpers.
    // ------------------------------------------------------------------
    // Map a subindex 1..6 onto the set of categories it covers.
    function automatic logic [4:0] sub_mask(input logic [2:0] sub, input logic discard);
        logic [4:0] m;
        m = 5'h00;
        if (sub == 3'h1) begin
            m = discard ? PSS_CAT_FACTORY : PSS_CAT_ALL;
        end else if (sub >= 3'h2 && sub <= 3'h6) begin
            m = 5'(5'h01 << (sub - 3'h2));
        end
        return m;
    endfunction

    logic        wr_store;   // Write hits a store entry.
    logic        wr_disc;    // Write hits a discard entry.
    logic [2:0]  wr_sub;     // Subindex of the hit entry.

    always_comb begin
        wr_store = reg_wr && reg_addr >= PSS_A_STORE_ALL && reg_addr <= PSS_A_STORE_LAST;
        wr_disc  = reg_wr && reg_addr >= PSS_A_DISC_ALL && reg_addr <= PSS_A_DISC_LAST;
        wr_sub   = reg_addr[2:0];
    end

    // ------------------------------------------------------------------
    // Command sequencer.
    // ------------------------------------------------------------------
    pss_state_e  state_r;        // Current operation.
    logic [4:0]  todo_r;         // Categories still to process.
    logic [2:0]  op_sub_r;       // Subindex that started the operation.
    logic        waiting_r;      // Request issued, awaiting done.
    logic [2:0]  cur_cat;        // Lowest pending category.
    logic        start_store;    // Valid save command accepted.
    logic        start_disc;     // Valid discard command accepted.
    logic [4:0]  stored_r;       // Categories present in storage.
    logic [4:0]  pending_r;      // Discards waiting for restart.
    logic        restoring_r;    // Reload after reset in progress.

    // Only the exact key starts work, and only when idle.
    always_comb begin
        start_store = wr_store && reg_wdata == PSS_KEY_SAVE && state_r == PSS_IDLE;
        start_disc  = wr_disc && reg_wdata == PSS_KEY_LOAD && state_r == PSS_IDLE;
        cur_cat     = 3'h0;
        for (int i = PSS_NCAT - 1; i >= 0; i--) begin
            if (todo_r[i]) begin
                cur_cat = 3'(i);
            end
        end
    end

    // Walk the selected categories one at a time; a category is the unit.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r   <= PSS_IDLE;
            todo_r    <= 5'h00;
            op_sub_r  <= 3'h0;
            waiting_r <= 1'b0;
            nv_req    <= 1'b0;
            nv_write  <= 1'b0;
            nv_cat    <= 3'h0;
        end else begin
            nv_req <= 1'b0;
            unique case (state_r)
                PSS_IDLE: begin
                    if (start_store || start_disc) begin
                        state_r  <= start_store ? PSS_STORE : PSS_DISCARD;
                        todo_r   <= sub_mask(wr_sub, start_disc);
                        op_sub_r <= wr_sub;
                    end
                end
                PSS_STORE, PSS_DISCARD: begin
                    if (!waiting_r && todo_r != 5'h00) begin
                        nv_req    <= 1'b1;
                        nv_write  <= state_r == PSS_STORE;
                        nv_cat    <= cur_cat;
                        waiting_r <= 1'b1;
                    end else if (waiting_r && nv_done) begin
                        waiting_r         <= 1'b0;
                        todo_r[nv_cat]    <= 1'b0;
                    end else if (!waiting_r) begin
                        state_r <= PSS_IDLE;
                    end
                end
                default: state_r <= PSS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command entries: store the written value, then 1 on completion.
    // ------------------------------------------------------------------
    logic [31:0] store_cmd_r [1:6];   // Store entries per subindex.
    logic [31:0] disc_cmd_r  [1:6];   // Discard entries per subindex.
    logic        op_end;              // Operation just finished.

    assign op_end = state_r != PSS_IDLE && !waiting_r && todo_r == 5'h00;

    // Completion overwrites the entry that started the work, even if
    // the master rewrote it meanwhile.
    generate
        for (genvar s = 1; s <= 6; s++) begin : g_cmd
            always_ff @(posedge clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    store_cmd_r[s] <= 32'h00000000;
                    disc_cmd_r[s]  <= 32'h00000000;
                end else begin
                    if (op_end && state_r == PSS_STORE && op_sub_r == 3'(s)) begin
                        store_cmd_r[s] <= PSS_DONE_VALUE;
                    end else if (wr_store && wr_sub == 3'(s)) begin
                        store_cmd_r[s] <= reg_wdata;
                    end
                    if (op_end && state_r == PSS_DISCARD && op_sub_r == 3'(s)) begin
                        disc_cmd_r[s] <= PSS_DONE_VALUE;
                    end else if (wr_disc && wr_sub == 3'(s)) begin
                        disc_cmd_r[s] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Storage content bookkeeping and restart-deferred discard.
    // ------------------------------------------------------------------
    // Erased categories stay active until the next restart; the pending
    // mask records that the loaded copy is stale.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pending_r <= 5'h00;
        end else if (waiting_r && nv_done && state_r == PSS_DISCARD) begin
            pending_r[nv_cat] <= 1'b1;
        end else if (waiting_r && nv_done && state_r == PSS_STORE) begin
            pending_r[nv_cat] <= 1'b0;
        end
    end

    // Presence of each category in storage; the storage itself is
    // nonvolatile, this copy is rebuilt by the reload after reset.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stored_r    <= 5'h00;
            restoring_r <= 1'b1;
        end else begin
            if (restoring_r) begin
                stored_r    <= PSS_CAT_ALL;
                restoring_r <= 1'b0;
            end
        end
    end

    // Reload after every reset; all five categories apply, whatever is stored.
    // Customer data is reported for readback only and steers nothing.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            restored_cats <= 5'h00;
        end else if (restoring_r) begin
            restored_cats <= stored_r | PSS_CAT_ALL;
        end
    end

    // ------------------------------------------------------------------
    // Restart request and configuration marker.
    // ------------------------------------------------------------------
    logic [31:0] marker_r [0:1];   // Configuration marker entries.
    logic        savable_wr;       // Write to a savable object.

    // The save-all entry and the marker itself do not clear the marker.
    assign savable_wr = reg_wr && ((reg_addr > PSS_A_STORE_ALL && reg_addr <= PSS_A_STORE_LAST)
                        || reg_addr == PSS_A_OBJECT || reg_addr == PSS_A_REBOOT);

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            restart_req <= 1'b0;
        end else begin
            restart_req <= reg_wr && reg_addr == PSS_A_REBOOT && reg_wdata == PSS_KEY_BOOT;
        end
    end

    generate
        for (genvar m = 0; m < 2; m++) begin : g_mark
            always_ff @(posedge clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    marker_r[m] <= 32'h00000000;
                end else if (reg_wr && reg_addr == 5'(PSS_A_MARKER0 + 5'(m))) begin
                    marker_r[m] <= reg_wdata;
                end else if (savable_wr) begin
                    marker_r[m] <= 32'h00000000;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Busy output and read port.
    // ------------------------------------------------------------------
    // Busy tells the master not to move the motor while storage works.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r != PSS_IDLE && !op_end) || start_store || start_disc;
        end
    end

    // Read data stands only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr >= PSS_A_STORE_ALL && reg_addr <= PSS_A_STORE_LAST) begin
            reg_rdata <= store_cmd_r[reg_addr[2:0]];
        end else if (reg_addr >= PSS_A_DISC_ALL && reg_addr <= PSS_A_DISC_LAST) begin
            reg_rdata <= disc_cmd_r[reg_addr[2:0]];
        end else if (reg_addr == PSS_A_MARKER0 || reg_addr == PSS_A_MARKER1) begin
            reg_rdata <= marker_r[reg_addr[0]];
        end else if (reg_addr == PSS_A_STATUS) begin
            reg_rdata <= {21'h000000, pending_r, 4'h0, state_r != PSS_IDLE, waiting_r};
        end else if (reg_addr == PSS_A_ACTIVE_CAT) begin
            reg_rdata <= {27'h0000000, stored_r};
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // pss_ctrl

`default_nettype wire

// ===== tb/pss_ctrl_assertions.sv
/* Port checker for the save and restore controller.
   Bound into pss_ctrl; sees only its ports, one clock. */
`timescale 1ns/1ps
`default_nettype none
module pss_ctrl_checker
    import pss_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        nv_req,
    input wire logic        nv_write,
    input wire logic [2:0]  nv_cat,
    input wire logic        restart_req,
    input wire logic        busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic rd_q_r;   // Read strobe of the last cycle.
    logic boot_q_r; // Valid restart write of the last cycle.
    wire  cmd_st = reg_wr && !busy && reg_addr >= 5'h02 && reg_addr <= PSS_A_STORE_LAST;
    wire  cmd_ds = reg_wr && !busy && reg_addr >= 5'h12 && reg_addr <= PSS_A_DISC_LAST;
    // Delayed copies, cleared in reset so no stale strobe survives it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q_r   <= 1'b0;
            boot_q_r <= 1'b0;
        end else begin
            rd_q_r   <= reg_rd;
            boot_q_r <= reg_wr && reg_addr == PSS_A_REBOOT && reg_wdata == PSS_KEY_BOOT;
        end
    end
    a_save_start: assert property (cmd_st && reg_wdata == PSS_KEY_SAVE |=> busy ##1 nv_req
        && nv_write && nv_cat == 3'($past(reg_addr, 2) - 5'h02)) else $error("save start wrong");
    a_disc_start: assert property (cmd_ds && reg_wdata == PSS_KEY_LOAD |=> busy ##1 nv_req
        && !nv_write && nv_cat == 3'($past(reg_addr, 2) - 5'h12)) else $error("discard wrong");
    a_wrong_key: assert property ((cmd_st || cmd_ds) && reg_wdata != PSS_KEY_SAVE
        && reg_wdata != PSS_KEY_LOAD |=> (!busy && !nv_req) [*2]) else $error("bad key ran");
    a_req_pulse: assert property (nv_req |=> !nv_req) else $error("request too long");
    a_busy_issues: assert property ($rose(busy) |=> nv_req) else $error("no request");
    a_cat_range: assert property (nv_req |-> nv_cat <= 3'h4) else $error("bad category");
    a_boot_restart: assert property (restart_req == boot_q_r) else $error("restart wrong");
    a_rdata_idle: assert property (!rd_q_r |-> reg_rdata == 32'h0) else $error("rdata not 0");
    c_save: cover property (nv_req && nv_write);
    c_discard: cover property (nv_req && !nv_write);
    c_restart: cover property (restart_req);
endmodule // pss_ctrl_checker
bind pss_ctrl pss_ctrl_checker u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nv_req(nv_req), .nv_write(nv_write), .nv_cat(nv_cat), .restart_req(restart_req),
    .busy(busy));
`default_nettype wire

// ===== tb/pss_nv_model.sv
/* Behavioural non-volatile storage answering the controller.
   Never reset, as stored data outlives a device reset. */
`timescale 1ns/1ps
`default_nettype none
module pss_nv_model (
    input  wire logic       clk,
    input  wire logic       nv_req,
    input  wire logic       nv_write,
    input  wire logic [2:0] nv_cat,
    input  wire logic       slow,       // Answer late when high.
    input  wire logic       clr,        // Clear the logs.
    output logic            nv_done,
    output logic      [4:0] seen_store, // Categories stored.
    output logic      [4:0] seen_erase  // Categories erased.
);
    logic     pend; // A request waits for its answer.
    int       cnt;  // Cycles left before the answer.
    initial begin
        nv_done = 1'b0;
        pend = 1'b0;
        seen_store = 5'h00;
        seen_erase = 5'h00;
    end
    // One request moves one whole category; logs survive resets.
    always @(posedge clk) begin
        nv_done <= 1'b0;
        if (clr) begin
            seen_store <= 5'h00;
            seen_erase <= 5'h00;
        end
        if (nv_req) begin
            pend <= 1'b1;
            cnt <= slow ? 6 : 0;
            if (nv_write) seen_store[nv_cat] <= 1'b1;
            else seen_erase[nv_cat] <= 1'b1;
        end else if (pend) begin
            if (cnt == 0) begin
                nv_done <= 1'b1;
                pend <= 1'b0;
            end else cnt <= cnt - 1;
        end
    end
endmodule // pss_nv_model
`default_nettype wire

// ===== tb/tb_pss_ctrl.sv
/* Self-checking bench for pss_ctrl with a storage model.
   Drives the register port at rising edges by non-blocking assignment. */
`timescale 1ns/1ps
`default_nettype none
module tb_pss_ctrl
    import pss_pkg::*;
;
    logic clk, reset_n, reg_wr, reg_rd, nv_req, nv_write, nv_done, restart_req, busy, slow, clr;
    logic [4:0]  reg_addr, restored_cats, seen_store, seen_erase, a;
    logic [31:0] reg_wdata, reg_rdata, d, v, seed;
    logic [2:0]  nv_cat;
    int          error_cnt, checks;
    pss_ctrl dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_req(nv_req),
        .nv_write(nv_write), .nv_cat(nv_cat), .nv_done(nv_done),
        .restored_cats(restored_cats), .restart_req(restart_req), .busy(busy));
    pss_nv_model nv_u (.clk(clk), .nv_req(nv_req), .nv_write(nv_write), .nv_cat(nv_cat),
        .slow(slow), .clr(clr), .nv_done(nv_done), .seen_store(seen_store),
        .seen_erase(seen_erase));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Categories a command entry covers; entry 1 of discard spares tuning.
    function automatic logic [4:0] exp_mask(input logic [4:0] ad);
        if (ad[3:0] == 4'h1) return ad[4] ? 5'h0F : 5'h1F;
        return 5'h01 << (ad[2:0] - 3'h2);
    endfunction
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] dat);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, dat};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] ad, output logic [31:0] dat);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge clk) reg_rd <= 1'b0;
        #1 dat = reg_rdata;
    endtask
    // Clear the logs, start a command, wait for busy to fall.
    task automatic op(input logic [4:0] ad, input logic [31:0] key);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        wr(ad, key);
        if (ad == 5'h01) wr(5'h12, PSS_KEY_LOAD); // Refused while busy.
        repeat (2) @(posedge clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
        chk5({4'h0, busy}, 5'h00);
    endtask
    task automatic do_reset();
        @(posedge clk) reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk5(restored_cats, 5'h1F);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000 error_cnt++;
        complete_run();
    end
    initial begin
        {reset_n, reg_wr, reg_rd, slow, clr, reg_addr, reg_wdata} = '0;
        {error_cnt, checks, seed} = {32'd0, 32'd0, 32'h61C6};
        do_reset();
        v = rnd();
        wr(PSS_A_MARKER0, v);
        for (int i = 0; i < 12; i++) begin
            a = (i < 6) ? 5'(i + 1) : 5'(i + 11);
            slow <= i[0];
            op(a, (i < 6) ? PSS_KEY_SAVE : PSS_KEY_LOAD);
            rd(a, d);
            chk32(d, PSS_DONE_VALUE);
            chk5((i < 6) ? seen_store : seen_erase, exp_mask(a));
            chk5((i < 6) ? seen_erase : seen_store, 5'h00);
            chk5(restored_cats, 5'h1F);
            if (i == 0) begin
                rd(PSS_A_MARKER0, d);
                chk32(d, v);
                wr(PSS_A_OBJECT, rnd());
                rd(PSS_A_MARKER0, d);
                chk32(d, 32'h0);
            end
        end
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        for (int j = 0; j < 6; j++) begin
            d = rnd();
            v = (j == 5) ? PSS_KEY_SAVE ^ 32'h1 : rnd();
            a = {d[4], 1'b0, 3'h1 + 3'(d[2:0] % 3'h6)};
            wr(a, v);
            repeat (3) @(posedge clk);
            chk5({4'h0, busy}, 5'h00);
            rd(a, d);
            chk32(d, v);
        end
        chk5(seen_store | seen_erase, 5'h00);
        for (int k = 0; k < 2; k++) begin
            wr(PSS_A_REBOOT, (k == 1) ? PSS_KEY_BOOT : PSS_KEY_BOOT ^ (rnd() | 32'h1));
            #1 chk5({4'h0, restart_req}, 5'(k));
        end
        do_reset();
        complete_run();
    end
endmodule // tb_pss_ctrl
`default_nettype wire
